// *** rssx_pkg.sv ***
// Package of constants and types for the rotate/subtract/swap/xor datapath
package rssx_pkg;
    localparam int DATA_W        = 8;
    localparam int ADDR_W        = 7;
    localparam int FILE_DEPTH    = 128;
    localparam int NIB_LO_MSB    = 3;
    localparam int NIB_HI_LSB    = 4;
    localparam int MSB           = 7;
    localparam int WDT_W         = 8;
    localparam int PRE_W         = 8;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [WDT_W-1:0]  WDT_CLR  = 8'h00;
    localparam logic [PRE_W-1:0]  PRE_CLR  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO     = 8'h00;
    localparam logic              DEST_ACC  = 1'b0;
    localparam logic              DEST_FILE = 1'b1;

    // Operation codes presented by the decoder
    typedef enum logic [3:0] {
        RSSX_OP_NONE,
        RSSX_OP_ROTATE_LEFT_VIA_CARRY,
        RSSX_OP_ROTATE_RIGHT_VIA_CARRY,
        RSSX_OP_LITERAL_MINUS_ACCUMULATOR,
        RSSX_OP_FILE_MINUS_ACCUMULATOR,
        RSSX_OP_NIBBLE_EXCHANGE,
        RSSX_OP_LITERAL_EXCLUSIVE_OR,
        RSSX_OP_FILE_EXCLUSIVE_OR,
        RSSX_OP_POWERDOWN
    } rssx_op_e;

    // Core run state
    typedef enum logic {
        RSSX_ST_RUN,
        RSSX_ST_SLEEP
    } rssx_state_e;
endpackage : rssx_pkg

// *** rssx_sub.sv ***
// Subtractor computing minuend minus subtrahend with borrow-style flags
module rssx_sub
    import rssx_pkg::*;
(
    // Operands
    input  wire logic [rssx_pkg::DATA_W-1:0] i_minuend,
    input  wire logic [rssx_pkg::DATA_W-1:0] i_subtrahend,
    // Results
    output logic      [rssx_pkg::DATA_W-1:0] o_diff,
    output logic                             o_carry,
    output logic                             o_dcarry
);
    logic [DATA_W:0]     full;
    logic [NIB_HI_LSB:0] low;

    // Extra bit gives the no-borrow carry for free
    assign full     = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + 9'h001;
    assign low      = {1'b0, i_minuend[NIB_LO_MSB:0]} + {1'b0, ~i_subtrahend[NIB_LO_MSB:0]}
                      + 5'h01;
    assign o_diff   = full[DATA_W-1:0];
    assign o_carry  = full[DATA_W];
    assign o_dcarry = low[NIB_HI_LSB];
endmodule : rssx_sub

// *** rssx_alu.sv ***
// Execution datapath: rotates, subtracts, nibble swap, xor and power-down
// Behaviour
// - Rotate file left through carry, address 0..127
// - Rotate file right through carry
// - Destination bit 0 writes the accumulator
// - Destination bit 1 writes the file register
// - Power-down clears watchdog counter and prescaler
// - Power-down clears powerdown flag, sets expiry flag
// - Power-down enters sleep, oscillator halted
// - Literal minus accumulator into accumulator
// - Subtracts set carry, digit carry, zero
// - File minus accumulator, routed by destination
// - Nibble exchange, no flags change
// - Literal xor into accumulator, zero only
// - File xor routed by destination, zero only
module rssx_alu
    import rssx_pkg::*;
(
    // Clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_arst_n,
    // Instruction issue
    input  wire logic                        i_exec,
    input  wire rssx_pkg::rssx_op_e          i_op,
    input  wire logic [rssx_pkg::ADDR_W-1:0] i_file_addr,
    input  wire logic                        i_dest,
    input  wire logic [rssx_pkg::DATA_W-1:0] i_literal,
    // Wake from sleep
    input  wire logic                        i_wake,
    // Watchdog tick
    input  wire logic                        i_wdt_tick,
    // File read port
    input  wire logic [rssx_pkg::ADDR_W-1:0] i_rd_addr,
    output logic      [rssx_pkg::DATA_W-1:0] o_rd_data,
    // Architectural state
    output logic      [rssx_pkg::DATA_W-1:0] o_acc,
    output logic                             o_carry,
    output logic                             o_dcarry,
    output logic                             o_zero,
    output logic                             o_powerdown_flag,
    output logic                             o_watchdog_expiry_flag,
    output logic      [rssx_pkg::WDT_W-1:0]  o_watchdog_counter,
    output logic      [rssx_pkg::PRE_W-1:0]  o_wdt_prescaler,
    output logic                             o_sleep,
    output logic                             o_osc_run
);
    logic [DATA_W-1:0] file_mem [FILE_DEPTH];
    logic [DATA_W-1:0] acc_r;
    logic              carry_r;
    logic              dcarry_r;
    logic              zero_r;
    logic              pd_flag_r;
    logic              to_flag_r;
    logic [WDT_W-1:0]  wdt_r;
    logic [PRE_W-1:0]  pre_r;
    rssx_state_e       state_r;
    logic [DATA_W-1:0] rd_data_r;
    logic              sleep_r;
    logic              osc_run_r;
    logic [ADDR_W-1:0] chk_addr_r;
    logic [DATA_W-1:0] chk_fval_r;

    // Operand fetch and subtract unit
    wire  [DATA_W-1:0] fval = file_mem[i_file_addr];
    wire  [DATA_W-1:0] sub_minuend;
    wire  [DATA_W-1:0] sub_diff;
    wire               sub_c;
    wire               sub_dc;
    wire               is_lit_sub = (i_op == RSSX_OP_LITERAL_MINUS_ACCUMULATOR);
    assign sub_minuend = is_lit_sub ? i_literal : fval;

    rssx_sub u_sub (
        .i_minuend    (sub_minuend),
        .i_subtrahend (acc_r),
        .o_diff       (sub_diff),
        .o_carry      (sub_c),
        .o_dcarry     (sub_dc)
    );

    // Decoded operation strobes; nothing executes while asleep
    wire run_ok  = i_exec && (state_r == RSSX_ST_RUN);
    wire op_rl   = run_ok && (i_op == RSSX_OP_ROTATE_LEFT_VIA_CARRY);
    wire op_rr   = run_ok && (i_op == RSSX_OP_ROTATE_RIGHT_VIA_CARRY);
    wire op_sl   = run_ok && is_lit_sub;
    wire op_sf   = run_ok && (i_op == RSSX_OP_FILE_MINUS_ACCUMULATOR);
    wire op_sw   = run_ok && (i_op == RSSX_OP_NIBBLE_EXCHANGE);
    wire op_xl   = run_ok && (i_op == RSSX_OP_LITERAL_EXCLUSIVE_OR);
    wire op_xf   = run_ok && (i_op == RSSX_OP_FILE_EXCLUSIVE_OR);
    wire op_pd   = run_ok && (i_op == RSSX_OP_POWERDOWN);
    wire has_dst = op_rl || op_rr || op_sf || op_sw || op_xf;

    // Result selection
    wire [DATA_W-1:0] rot_l = {fval[MSB-1:0], carry_r};
    wire [DATA_W-1:0] rot_r = {carry_r, fval[MSB:1]};
    wire [DATA_W-1:0] swp   = {fval[NIB_LO_MSB:0], fval[MSB:NIB_HI_LSB]};
    wire [DATA_W-1:0] xr_l  = acc_r ^ i_literal;
    wire [DATA_W-1:0] xr_f  = acc_r ^ fval;
    wire [DATA_W-1:0] result = op_rl ? rot_l :
                               op_rr ? rot_r :
                               op_sw ? swp :
                               op_xl ? xr_l :
                               op_xf ? xr_f : sub_diff;
    wire res_zero = (result == ZERO);

    // Write targets
    wire acc_we  = op_sl || op_xl || (has_dst && (i_dest == DEST_ACC));
    wire file_we = has_dst && (i_dest == DEST_FILE);

    // Flag updates
    wire c_we    = op_rl || op_rr || op_sl || op_sf;
    wire c_nxt   = op_rl ? fval[MSB] : op_rr ? fval[0] : sub_c;
    wire dc_we   = op_sl || op_sf;
    wire z_we    = op_sl || op_sf || op_xl || op_xf;

    // One flop row per entry; reset to zero so no address ever reads unknown
    for (genvar g = 0; g < FILE_DEPTH; g++) begin : g_file
        always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                file_mem[g] <= DATA_RST;
            end else if (file_we && (i_file_addr == ADDR_W'(g))) begin
                file_mem[g] <= result;
            end
        end
    end

    // Registered file read port
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_data_r <= DATA_RST;
        end else begin
            rd_data_r <= file_mem[i_rd_addr];
        end
    end

    // Accumulator
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            acc_r <= DATA_RST;
        end else if (acc_we) begin
            acc_r <= result;
        end
    end

    // Arithmetic flags
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            carry_r  <= 1'b0;
            dcarry_r <= 1'b0;
            zero_r   <= 1'b0;
        end else begin
            if (c_we) carry_r <= c_nxt;
            if (dc_we) dcarry_r <= sub_dc;
            if (z_we) zero_r <= res_zero;
        end
    end

    // Power status flags; reset is the power-up state
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pd_flag_r <= 1'b1;
            to_flag_r <= 1'b1;
        end else if (op_pd) begin
            pd_flag_r <= 1'b0;
            to_flag_r <= 1'b1;
        end
    end

    // Watchdog counter and prescaler; clear wins over tick
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wdt_r <= WDT_CLR;
            pre_r <= PRE_CLR;
        end else if (op_pd) begin
            wdt_r <= WDT_CLR;
            pre_r <= PRE_CLR;
        end else if (i_wdt_tick) begin
            pre_r <= pre_r + 8'h01;
            if (pre_r == 8'hFF) wdt_r <= wdt_r + 8'h01;
        end
    end

    // Run/sleep state; wake only leaves sleep
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= RSSX_ST_RUN;
        end else begin
            unique case (state_r)
                RSSX_ST_RUN: begin
                    if (op_pd) state_r <= RSSX_ST_SLEEP;
                end
                RSSX_ST_SLEEP: begin
                    if (i_wake) state_r <= RSSX_ST_RUN;
                end
            endcase
        end
    end

    // Sleep and oscillator pins get their own flops so they never glitch
    wire sleep_nxt = (state_r == RSSX_ST_RUN) ? op_pd : !i_wake;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sleep_r   <= 1'b0;
            osc_run_r <= 1'b1;
        end else begin
            sleep_r   <= sleep_nxt;
            osc_run_r <= !sleep_nxt;
        end
    end

    // Operand snapshot so checks can see the file word an instruction read
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chk_addr_r <= '0;
            chk_fval_r <= DATA_RST;
        end else begin
            chk_addr_r <= i_file_addr;
            chk_fval_r <= fval;
        end
    end

    // Outputs straight from flip-flops
    assign o_rd_data              = rd_data_r;
    assign o_acc                  = acc_r;
    assign o_carry                = carry_r;
    assign o_dcarry               = dcarry_r;
    assign o_zero                 = zero_r;
    assign o_powerdown_flag       = pd_flag_r;
    assign o_watchdog_expiry_flag = to_flag_r;
    assign o_watchdog_counter     = wdt_r;
    assign o_wdt_prescaler        = pre_r;
    assign o_sleep                = sleep_r;
    assign o_osc_run              = osc_run_r;

    // Checks
    AST_ROT_L: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_rl && i_dest == DEST_ACC |=> acc_r == {$past(fval[MSB-1:0]), $past(carry_r)}
        && carry_r == $past(fval[MSB])) else $error("rotate left wrong");
    AST_ROT_R: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_rr && i_dest == DEST_ACC |=> acc_r == {$past(carry_r), $past(fval[MSB:1])}
        && carry_r == $past(fval[0])) else $error("rotate right wrong");
    AST_DEST_FILE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        has_dst && i_dest == DEST_FILE |=> $stable(acc_r)) else $error("acc changed");
    AST_PD_WDT: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_pd |=> wdt_r == WDT_CLR && pre_r == PRE_CLR) else $error("wdt not clear");
    AST_PD_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_pd |=> !pd_flag_r && to_flag_r && $stable(carry_r) && $stable(dcarry_r)
        && $stable(zero_r))
        else $error("pd flags wrong");
    AST_SLEEP: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_pd |=> o_sleep && !o_osc_run) else $error("no sleep");
    AST_SUBL: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sl |=> acc_r == 8'($past(i_literal) - $past(acc_r))
        && carry_r == ($past(acc_r) <= $past(i_literal))) else $error("sub literal wrong");
    AST_DC: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sl |=> dcarry_r == ($past(acc_r[NIB_LO_MSB:0]) <= $past(i_literal[NIB_LO_MSB:0])))
        else $error("digit carry wrong");
    AST_SWAP: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sw && i_dest == DEST_ACC |=> acc_r == {$past(fval[NIB_LO_MSB:0]),
        $past(fval[MSB:NIB_HI_LSB])} && $stable(carry_r) && $stable(zero_r))
        else $error("swap wrong");
    AST_XORL: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_xl |=> acc_r == ($past(acc_r) ^ $past(i_literal)) && zero_r == (acc_r == ZERO)
        && $stable(carry_r)) else $error("xor literal wrong");
    // File-side checks use the snapshot of the word read at issue
    AST_SUBF_ACC: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sf && i_dest == DEST_ACC |=> acc_r == 8'(chk_fval_r - $past(acc_r)))
        else $error("sub file to acc wrong");
    AST_SUBF_FILE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sf && i_dest == DEST_FILE |=> file_mem[chk_addr_r] == 8'(chk_fval_r - $past(acc_r))
        && $stable(acc_r)) else $error("sub file to file wrong");
    AST_SUBF_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sf |=> carry_r == ($past(acc_r) <= chk_fval_r)
        && dcarry_r == ($past(acc_r[NIB_LO_MSB:0]) <= chk_fval_r[NIB_LO_MSB:0])
        && zero_r == (chk_fval_r == $past(acc_r))) else $error("sub file flags wrong");
    AST_FILE_KEEP: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        has_dst && i_dest == DEST_ACC |=> file_mem[chk_addr_r] == chk_fval_r)
        else $error("file changed");
    AST_ROT_L_FILE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_rl && i_dest == DEST_FILE |=> file_mem[chk_addr_r] == {chk_fval_r[MSB-1:0],
        $past(carry_r)}) else $error("rotate left file wrong");
    AST_ROT_R_FILE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_rr && i_dest == DEST_FILE |=> file_mem[chk_addr_r] == {$past(carry_r),
        chk_fval_r[MSB:1]}) else $error("rotate right file wrong");
    AST_SWAP_FILE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sw && i_dest == DEST_FILE |=> file_mem[chk_addr_r] == {chk_fval_r[NIB_LO_MSB:0],
        chk_fval_r[MSB:NIB_HI_LSB]} && $stable(carry_r) && $stable(dcarry_r)
        && $stable(zero_r)) else $error("swap file wrong");
    AST_XORF: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_xf |=> zero_r == ((chk_fval_r ^ $past(acc_r)) == ZERO) && $stable(carry_r)
        && $stable(dcarry_r)) else $error("xor file flags wrong");
    AST_XORF_ACC: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_xf && i_dest == DEST_ACC |=> acc_r == (chk_fval_r ^ $past(acc_r)))
        else $error("xor file to acc wrong");
    AST_SUBL_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        op_sl |=> zero_r == (acc_r == ZERO)) else $error("sub literal zero wrong");
    AST_SLEEP_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        state_r == RSSX_ST_SLEEP && i_exec && !i_wake |=> $stable(acc_r) && $stable(carry_r)
        && $stable(zero_r) && o_sleep && !o_osc_run) else $error("executed in sleep");
    AST_WAKE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        o_sleep && i_wake |=> !o_sleep && o_osc_run) else $error("no wake");
endmodule : rssx_alu

// *** rssx_alu_tb_top.sv ***
// Self-checking testbench for the rotate/subtract/swap/xor datapath
module rssx_alu_tb_top
    import rssx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             i_ref_clk;
    logic             i_arst_n;
    logic             i_exec;
    rssx_op_e         i_op;
    logic [ADDR_W-1:0] i_file_addr;
    logic             i_dest;
    logic [7:0]       i_literal;
    logic             i_wake;
    logic             i_wdt_tick;
    logic [ADDR_W-1:0] i_rd_addr;
    logic [7:0]       o_rd_data;
    logic [7:0]       o_acc;
    logic             o_carry;
    logic             o_dcarry;
    logic             o_zero;
    logic             o_powerdown_flag;
    logic             o_watchdog_expiry_flag;
    logic [7:0]       o_watchdog_counter;
    logic [7:0]       o_wdt_prescaler;
    logic             o_sleep;
    logic             o_osc_run;
    int               err_count;
    int               n_checks;
    logic [7:0]       acc_m;
    logic [7:0]       ta [7] = '{8'h37, 8'h48, 8'h08, 8'h00, 8'hFF, 8'h0F, 8'hF0};
    logic [7:0]       tk [7] = '{8'h37, 8'h50, 8'h07, 8'h00, 8'h00, 8'hF0, 8'h0F};

    rssx_alu i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_exec(i_exec), .i_op(i_op),
        .i_file_addr(i_file_addr), .i_dest(i_dest), .i_literal(i_literal), .i_wake(i_wake),
        .i_wdt_tick(i_wdt_tick), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_acc(o_acc),
        .o_carry(o_carry), .o_dcarry(o_dcarry), .o_zero(o_zero),
        .o_powerdown_flag(o_powerdown_flag), .o_watchdog_expiry_flag(o_watchdog_expiry_flag),
        .o_watchdog_counter(o_watchdog_counter), .o_wdt_prescaler(o_wdt_prescaler),
        .o_sleep(o_sleep), .o_osc_run(o_osc_run));

    // 250 MHz core clock
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Drive one instruction; the next call keeps i_exec high for back-to-back issue
    task automatic issue(input rssx_op_e op, input logic [7:0] lit, input logic d);
        @(negedge i_ref_clk);
        i_exec = 1'b1;
        i_op = op;
        i_literal = lit;
        i_dest = d;
    endtask : issue

    task automatic idle();
        @(negedge i_ref_clk);
        i_exec = 1'b0;
        i_op = RSSX_OP_NONE;
    endtask : idle

    // Accumulator loaded by xor, then subtracted in the very next cycle
    task automatic sub_case(input logic [7:0] a, input logic [7:0] k);
        logic [7:0] d;
        d = k - a;
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, acc_m ^ a, 1'b1);
        issue(RSSX_OP_LITERAL_MINUS_ACCUMULATOR, k, 1'b1);
        idle();
        acc_m = d;
        chk("sub acc", o_acc, d);
        chk("sub flags", {5'h00, o_carry, o_dcarry, o_zero},
            {5'h00, a <= k, a[3:0] <= k[3:0], d == 8'h00});
    endtask : sub_case

    task automatic xor_zero();
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, 8'h5A, 1'b0);
        idle();
        chk("xor acc", o_acc, 8'h5A);
        chk("xor flags", {5'h00, o_carry, o_dcarry, o_zero}, 8'h00);
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, 8'h5A, 1'b0);
        idle();
        chk("xor acc zero", o_acc, 8'h00);
        chk("xor zero flag", {5'h00, o_carry, o_dcarry, o_zero}, 8'h01);
        acc_m = 8'h00;
    endtask : xor_zero

    // Prescaler wrap, power-down with a coincident tick, refusal in sleep, wake
    task automatic power_case();
        @(negedge i_ref_clk);
        i_wdt_tick = 1'b1;
        repeat (258) @(negedge i_ref_clk);
        i_wdt_tick = 1'b0;
        chk("wdt count", o_watchdog_counter, 8'h01);
        chk("wdt prescaler", o_wdt_prescaler, 8'h02);
        issue(RSSX_OP_POWERDOWN, 8'h00, 1'b0);
        i_wdt_tick = 1'b1;
        idle();
        i_wdt_tick = 1'b0;
        chk("pd wdt", o_watchdog_counter, 8'h00);
        chk("pd prescaler", o_wdt_prescaler, 8'h00);
        chk("pd status", {4'h0, o_powerdown_flag, o_watchdog_expiry_flag, o_sleep, o_osc_run},
            8'h06);
        chk("pd flags", {5'h00, o_carry, o_dcarry, o_zero}, 8'h02);
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, 8'hFF, 1'b0);
        idle();
        chk("sleep acc", o_acc, acc_m);
        i_wake = 1'b1;
        @(negedge i_ref_clk);
        i_wake = 1'b0;
        chk("wake status", {4'h0, o_powerdown_flag, o_watchdog_expiry_flag, o_sleep, o_osc_run},
            8'h05);
    endtask : power_case

    // File memory resets to zero, so a swap of it clears the accumulator
    task automatic file_case();
        issue(RSSX_OP_NIBBLE_EXCHANGE, 8'h00, 1'b0);
        idle();
        chk("swap flags", {5'h00, o_carry, o_dcarry, o_zero}, 8'h02);
        chk("swap acc", o_acc, 8'h00);
        issue(RSSX_OP_FILE_EXCLUSIVE_OR, 8'h00, 1'b1);
        idle();
        chk("fxor flags", {6'h00, o_carry, o_dcarry}, 8'h01);
        acc_m = 8'h00;
    endtask : file_case

    // Seed one file word through the xor path, then rotate, subtract and swap it
    task automatic file_ops();
        i_file_addr = 7'h10;
        i_rd_addr = 7'h10;
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, acc_m ^ 8'hE6, 1'b0);
        issue(RSSX_OP_FILE_EXCLUSIVE_OR, 8'h00, 1'b1);
        issue(RSSX_OP_LITERAL_EXCLUSIVE_OR, 8'hE6, 1'b0);
        issue(RSSX_OP_ROTATE_LEFT_VIA_CARRY, 8'h00, 1'b0);
        idle();
        chk("rl acc", o_acc, 8'hCC);
        chk("rl carry", {7'h00, o_carry}, 8'h01);
        chk("rl file kept", o_rd_data, 8'hE6);
        issue(RSSX_OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 1'b1);
        issue(RSSX_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 1'b0);
        idle();
        chk("rr file", o_rd_data, 8'hF3);
        chk("subf acc", o_acc, 8'h27);
        chk("subf flags", {5'h00, o_carry, o_dcarry, o_zero}, 8'h04);
        issue(RSSX_OP_NIBBLE_EXCHANGE, 8'h00, 1'b1);
        issue(RSSX_OP_FILE_MINUS_ACCUMULATOR, 8'h00, 1'b1);
        issue(RSSX_OP_FILE_EXCLUSIVE_OR, 8'h00, 1'b0);
        idle();
        chk("fxor acc", o_acc, 8'h3F);
        chk("fxor flags kept", {5'h00, o_carry, o_dcarry, o_zero}, 8'h06);
        chk("subf file", o_rd_data, 8'h18);
        acc_m = 8'h3F;
    endtask : file_ops

    // Main sequence
    initial begin
        err_count = 0;
        n_checks = 0;
        acc_m = 8'h00;
        i_arst_n = 1'b0;
        i_exec = 1'b0;
        i_op = RSSX_OP_NONE;
        i_file_addr = 7'h7F;
        i_dest = 1'b0;
        i_literal = 8'h00;
        i_wake = 1'b0;
        i_wdt_tick = 1'b0;
        i_rd_addr = 7'h7F;
        repeat (6) @(negedge i_ref_clk);
        chk("reset rd data", o_rd_data, 8'h00);
        i_arst_n = 1'b1;
        chk("reset acc", o_acc, 8'h00);
        chk("reset status", {4'h0, o_powerdown_flag, o_watchdog_expiry_flag, o_sleep, o_osc_run},
            8'h0D);
        chk("reset wdt", o_watchdog_counter | o_wdt_prescaler, 8'h00);
        xor_zero();
        for (int i = 0; i < 7; i++) begin
            sub_case(ta[i], tk[i]);
        end
        power_case();
        file_case();
        file_ops();
        test_done();
    end

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #20us;
        err_count++;
        test_done();
    end
endmodule : rssx_alu_tb_top
